// ---- em_port_test_sigmon.sv ----
// Operation
// - Count each signaling bit transition, alarm above 255.
// - Monitor enable toggled by one command.
// - Test indication: n/a when inactive, else off/on.
// - Transmit ABCD: monitor or send chosen pattern.
// - Receive ABCD: monitor or substitute chosen pattern.
// - Bus-connect systems forbid receive override.
// - E lead set: off drops, on raises.
// - Cross-connect: inject tone or silence toward user.
// - Cross-connect: inject tone or silence toward network.
// - Bus-connect: tone injection unavailable, reads n/a.
// - Read back transmitted ABCD bits.
// - Read back received ABCD bits after substitution.
// - Separate E-lead and M-lead read-backs.
// - Read-only port mode indication.
// - Port status encodes twelve conditions.
// - Status shows test when override applied.
// - Read-only signaling type with trunk indicator.
module em_port_test_sigmon #(
    parameter longint WINDOW_CYCLES = em_test_pkg::WINDOW_CYCLES,
    parameter int PCM_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_active,
    input wire logic wan_active,
    input wire logic cross_connect,
    input wire logic [3:0] base_status,
    input wire logic [1:0] port_mode,
    input wire logic [1:0] strap_type,
    input wire logic strap_trunk,
    input wire logic [3:0] tx_abcd_in,
    input wire logic [3:0] rx_abcd_in,
    input wire logic e_lead_in,
    input wire logic m_lead_pin,
    input wire logic [PCM_W-1:0] pcm_from_net,
    input wire logic [PCM_W-1:0] pcm_from_user,
    input wire logic [PCM_W-1:0] tone_300,
    input wire logic [PCM_W-1:0] tone_1k,
    input wire logic [PCM_W-1:0] tone_3k,
    input wire logic [PCM_W-1:0] quiet_code,
    output logic [3:0] tx_abcd_out,
    output logic [3:0] rx_abcd_out,
    output logic e_lead_out,
    output logic [PCM_W-1:0] pcm_user_side_tone_inject,
    output logic [PCM_W-1:0] pcm_to_net,
    output logic transition_alarm,
    output logic irq
);

    // Software-written control state.
    logic tx_set;
    logic rx_set;
    logic e_set;
    logic e_val;
    logic [3:0] tx_pat;
    logic [3:0] rx_pat;
    logic test_on;
    logic mon_en;
    logic [2:0] user_tone;
    logic [2:0] net_tone;
    logic irq_status;
    logic irq_mask;
    // Three-stage synchroniser for the M lead pin.
    logic [2:0] m_sync;
    logic m_lead;
    // Window timebase and per-bit counters.
    logic [31:0] win_cnt;
    logic win_end;
    logic [7:0] tx_cnt [4];
    logic [7:0] rx_cnt [4];
    logic [3:0] tx_prev;
    logic [3:0] rx_prev;
    logic [7:0] over;
    logic alarm_event;
    // Bus decode.
    logic wr;
    logic rd;
    // Derived status.
    logic override;
    logic [1:0] test_ind;
    logic [3:0] port_status;
    logic [2:0] user_tone_rb;
    logic [2:0] net_tone_rb;

    // Map a tone selection to a PCM sample; anything unknown passes PCM.
    function automatic logic [PCM_W-1:0] tone_mux(
        input logic [2:0] sel,
        input logic [PCM_W-1:0] pass
    );
        case (sel)
            em_test_pkg::TONE_300: tone_mux = tone_300;
            em_test_pkg::TONE_1K: tone_mux = tone_1k;
            em_test_pkg::TONE_3K: tone_mux = tone_3k;
            em_test_pkg::TONE_QUIET: tone_mux = quiet_code;
            default: tone_mux = pass;
        endcase
    endfunction

    // Register decode. The slave answers in the first access cycle.
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;

    // Control register writes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_set <= 1'b0;
            rx_set <= 1'b0;
            e_set <= 1'b0;
            e_val <= 1'b0;
            tx_pat <= 4'h0;
            rx_pat <= 4'h0;
            test_on <= 1'b0;
        end
        else if (wr && paddr == em_test_pkg::OFF_CTRL)
        begin
            tx_set <= pwdata[em_test_pkg::CTRL_TX_SET];
            // Receive override is refused outright in bus-connect systems.
            rx_set <= pwdata[em_test_pkg::CTRL_RX_SET] && cross_connect;
            e_set <= pwdata[em_test_pkg::CTRL_E_SET];
            e_val <= pwdata[em_test_pkg::CTRL_E_VAL];
            tx_pat <= pwdata[em_test_pkg::CTRL_TX_PAT +: 4];
            rx_pat <= pwdata[em_test_pkg::CTRL_RX_PAT +: 4];
            test_on <= pwdata[em_test_pkg::CTRL_TEST];
        end
        else if (!cross_connect)
        begin
            // A later change to bus-connect drops a held receive override.
            rx_set <= 1'b0;
        end
    end

    // Tone selection writes; values above quiet fall back to PCM.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            user_tone <= em_test_pkg::TONE_PCM;
            net_tone <= em_test_pkg::TONE_PCM;
        end
        else if (wr && paddr == em_test_pkg::OFF_TONE)
        begin
            user_tone <= pwdata[em_test_pkg::TONE_USER +: 3];
            net_tone <= pwdata[em_test_pkg::TONE_NET +: 3];
        end
    end

    // Single command toggles the transition monitor enable.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mon_en <= 1'b0;
        else if (wr && paddr == em_test_pkg::OFF_MONITOR
                 && pwdata[em_test_pkg::MON_TOGGLE])
            mon_en <= !mon_en;
    end

    // Interrupt mask register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= 1'b0;
        else if (wr && paddr == em_test_pkg::OFF_IRQ_MASK)
            irq_mask <= pwdata[em_test_pkg::IRQ_TRANS];
    end

    // Sticky interrupt bit; a new event wins over a write-one clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= 1'b0;
        else if (alarm_event)
            irq_status <= 1'b1;
        else if (wr && paddr == em_test_pkg::OFF_IRQ_STATUS
                 && pwdata[em_test_pkg::IRQ_TRANS])
            irq_status <= 1'b0;
    end

    assign irq = irq_status && irq_mask;

    // The M lead comes from the trunk pin, so it is synchronised.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            m_sync <= 3'h0;
        else
            m_sync <= {m_sync[1:0], m_lead_pin};
    end

    // The lead state only moves once the last two stages agree.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            m_lead <= 1'b0;
        else if (m_sync[1] == m_sync[2])
            m_lead <= m_sync[2];
    end

    // Free-running four-second timebase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            win_cnt <= 32'h0;
        else if (win_end)
            win_cnt <= 32'h0;
        else
            win_cnt <= win_cnt + 32'h1;
    end

    assign win_end = (win_cnt == 32'(WINDOW_CYCLES - 1));

    // Previous bit values for edge detection on both directions.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_prev <= 4'h0;
            rx_prev <= 4'h0;
        end
        else
        begin
            tx_prev <= tx_abcd_out;
            rx_prev <= rx_abcd_out;
        end
    end

    // One saturating counter per bit and direction.
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_cnt
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    tx_cnt[i] <= 8'h0;
                    rx_cnt[i] <= 8'h0;
                end
                else if (win_end || !port_active)
                begin
                    tx_cnt[i] <= 8'h0;
                    rx_cnt[i] <= 8'h0;
                end
                else
                begin
                    // Saturation keeps a storm from wrapping back quiet.
                    if (tx_prev[i] != tx_abcd_out[i] && tx_cnt[i] != 8'hff)
                        tx_cnt[i] <= tx_cnt[i] + 8'h1;
                    if (rx_prev[i] != rx_abcd_out[i] && rx_cnt[i] != 8'hff)
                        rx_cnt[i] <= rx_cnt[i] + 8'h1;
                end
            end
            // Count 255 means the 256th edge: one above the limit.
            assign over[i] = tx_prev[i] != tx_abcd_out[i]
                && tx_cnt[i] == 8'(em_test_pkg::TRANS_LIMIT);
            assign over[i + 4] = rx_prev[i] != rx_abcd_out[i]
                && rx_cnt[i] == 8'(em_test_pkg::TRANS_LIMIT);
        end
    endgenerate

    // An alarm only exists for an active port with supervision on.
    assign alarm_event = mon_en && port_active && !win_end
        && (|over);

    // Alarm level to the card alarm system, held until the window ends or supervision is switched off.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            transition_alarm <= 1'b0;
        else if (alarm_event)
            transition_alarm <= 1'b1;
        else if (win_end || !mon_en)
            transition_alarm <= 1'b0;
    end

    // Signaling and E-lead outputs with overrides applied.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_abcd_out <= 4'h0;
            rx_abcd_out <= 4'h0;
            e_lead_out <= 1'b0;
        end
        else
        begin
            tx_abcd_out <= tx_set ? tx_pat : tx_abcd_in;
            rx_abcd_out <= rx_set ? rx_pat : rx_abcd_in;
            e_lead_out <= e_set ? e_val : e_lead_in;
        end
    end

    // PCM paths; tone injection only in cross-connect systems.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pcm_user_side_tone_inject <= '0;
            pcm_to_net <= '0;
        end
        else if (cross_connect)
        begin
            pcm_user_side_tone_inject <= tone_mux(user_tone, pcm_from_net);
            pcm_to_net <= tone_mux(net_tone, pcm_from_user);
        end
        else
        begin
            pcm_user_side_tone_inject <= pcm_from_net;
            pcm_to_net <= pcm_from_user;
        end
    end

    // Derived status views.
    assign override = tx_set || rx_set || e_set;
    assign test_ind = (!port_active || !wan_active) ? em_test_pkg::TEST_NA
        : ((test_on || override) ? em_test_pkg::TEST_ON
        : em_test_pkg::TEST_OFF);
    assign port_status = override ? em_test_pkg::PS_TEST
        : base_status;
    assign user_tone_rb = cross_connect ? user_tone
        : em_test_pkg::TONE_NA;
    assign net_tone_rb = cross_connect ? net_tone : em_test_pkg::TONE_NA;

    // Read data multiplexer; unmapped addresses read zero.
    always_comb
    begin
        prdata = 32'h0;
        if (rd)
        begin
            case (paddr)
                em_test_pkg::OFF_CTRL:
                begin
                    prdata[em_test_pkg::CTRL_TX_SET] = tx_set;
                    prdata[em_test_pkg::CTRL_RX_SET] = rx_set;
                    prdata[em_test_pkg::CTRL_E_SET] = e_set;
                    prdata[em_test_pkg::CTRL_E_VAL] = e_val;
                    prdata[em_test_pkg::CTRL_TX_PAT +: 4] = tx_pat;
                    prdata[em_test_pkg::CTRL_RX_PAT +: 4] = rx_pat;
                    prdata[em_test_pkg::CTRL_TEST] = test_on;
                end
                em_test_pkg::OFF_TONE:
                begin
                    prdata[em_test_pkg::TONE_USER +: 3] = user_tone_rb;
                    prdata[em_test_pkg::TONE_NET +: 3] = net_tone_rb;
                end
                em_test_pkg::OFF_STATUS:
                begin
                    prdata[em_test_pkg::ST_PORT +: 4] = port_status;
                    prdata[em_test_pkg::ST_TEST +: 2] = test_ind;
                    prdata[em_test_pkg::ST_USER +: 3] = user_tone_rb;
                    prdata[em_test_pkg::ST_NET +: 3] = net_tone_rb;
                end
                em_test_pkg::OFF_READBACK:
                begin
                    prdata[em_test_pkg::RB_TX +: 4] = tx_abcd_out;
                    prdata[em_test_pkg::RB_RX +: 4] = rx_abcd_out;
                    prdata[em_test_pkg::RB_E] = e_lead_out;
                    prdata[em_test_pkg::RB_M] = m_lead;
                    prdata[em_test_pkg::RB_MODE +: 2] = port_mode;
                    prdata[em_test_pkg::RB_TYPE +: 2] = strap_type;
                    prdata[em_test_pkg::RB_TRUNK] = strap_trunk;
                end
                em_test_pkg::OFF_IRQ_STATUS:
                    prdata[em_test_pkg::IRQ_TRANS] = irq_status;
                em_test_pkg::OFF_IRQ_MASK:
                    prdata[em_test_pkg::IRQ_TRANS] = irq_mask;
                em_test_pkg::OFF_MONITOR:
                    prdata[em_test_pkg::MON_TOGGLE] = mon_en;
                default:
                    prdata = 32'h0;
            endcase
        end
    end

    // Checks on the override, alarm and status behaviour.
    sequence s_toggle_cmd;
        wr && paddr == em_test_pkg::OFF_MONITOR
            && pwdata[em_test_pkg::MON_TOGGLE];
    endsequence

    a_tx_override: assert property (@(posedge pclk) disable iff (!presetn)
        tx_set |=> tx_abcd_out == $past(tx_pat))
        else $error("tx override pattern not sent");

    a_rx_override: assert property (@(posedge pclk) disable iff (!presetn)
        rx_set |=> rx_abcd_out == $past(rx_pat))
        else $error("rx override pattern not applied");

    a_rx_bus_block: assert property (@(posedge pclk) disable iff (!presetn)
        !cross_connect |=> !rx_set)
        else $error("rx override held in bus-connect");

    a_e_lead_force: assert property (@(posedge pclk) disable iff (!presetn)
        e_set |=> e_lead_out == $past(e_val))
        else $error("E lead not forced");

    a_mon_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        s_toggle_cmd |=> mon_en != $past(mon_en))
        else $error("monitor enable did not toggle");

    // The alarm level itself, not its source, must stay low when off.
    a_alarm_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !mon_en |=> !transition_alarm)
        else $error("alarm raised with supervision off");

    // The receive bit A counter is the one a signaling storm drives.
    a_count_saturate: assert property (@(posedge pclk) disable iff (!presetn)
        rx_cnt[0] == 8'hff && !win_end && port_active
        |=> rx_cnt[0] == 8'hff)
        else $error("counter wrapped");

    // Checked on the bus read path, where software actually sees it.
    a_status_test: assert property (@(posedge pclk) disable iff (!presetn)
        override && rd && paddr == em_test_pkg::OFF_STATUS
        |-> prdata[em_test_pkg::ST_PORT +: 4] == em_test_pkg::PS_TEST)
        else $error("test status missing under override");

    a_tone_bus_na: assert property (@(posedge pclk) disable iff (!presetn)
        !cross_connect |=> pcm_user_side_tone_inject == $past(pcm_from_net))
        else $error("tone injected in bus-connect");

    a_test_na: assert property (@(posedge pclk) disable iff (!presetn)
        !port_active |-> test_ind == em_test_pkg::TEST_NA)
        else $error("test indication not n/a");

endmodule

// ---- em_test_pkg.sv ----
package em_test_pkg;

    // APB register byte offsets, one aligned word each.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TONE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_READBACK = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_MONITOR = 8'h18;

    // Control register fields.
    localparam int CTRL_TX_SET = 0;
    localparam int CTRL_RX_SET = 1;
    localparam int CTRL_E_SET = 2;
    localparam int CTRL_E_VAL = 3;
    localparam int CTRL_TX_PAT = 4;
    localparam int CTRL_RX_PAT = 8;
    localparam int CTRL_TEST = 12;

    // Monitor register: writing one to this bit toggles the enable.
    localparam int MON_TOGGLE = 0;

    // Tone register fields, three bits per direction.
    localparam int TONE_USER = 0;
    localparam int TONE_NET = 4;

    // Readback register fields.
    localparam int RB_TX = 0;
    localparam int RB_RX = 4;
    localparam int RB_E = 8;
    localparam int RB_M = 9;
    localparam int RB_MODE = 12;
    localparam int RB_TYPE = 16;
    localparam int RB_TRUNK = 18;

    // Status register fields.
    localparam int ST_PORT = 0;
    localparam int ST_TEST = 4;
    localparam int ST_USER = 8;
    localparam int ST_NET = 12;

    // Interrupt bits.
    localparam int IRQ_TRANS = 0;

    // Transition limit and supervision window.
    localparam int TRANS_LIMIT = 255;
    localparam int WINDOW_S = 4;
    localparam longint CLK_HZ = 10_000_000;
    localparam longint WINDOW_CYCLES = WINDOW_S * CLK_HZ;

    // Tone selections; the value seven reads as not-applicable.
    typedef enum logic [2:0] {
        TONE_PCM, TONE_300, TONE_1K, TONE_3K, TONE_QUIET, TONE_NA = 3'h7
    } tone_t;

    // Test indication encoding.
    typedef enum logic [1:0] {TEST_NA, TEST_OFF, TEST_ON} test_ind_t;

    // Port status conditions.
    typedef enum logic [3:0] {
        PS_PORT_STANDBY, PS_WAN_STANDBY, PS_WAN_TEST, PS_WAN_OOS,
        PS_WAN_MISSING, PS_CARD_OOS, PS_CALL_SETUP, PS_CALL_BUSY,
        PS_IDLE, PS_TRUNK_COND, PS_TEST, PS_MAINT
    } port_status_t;

    // Port modes reported read-only.
    typedef enum logic [1:0] {
        MODE_EM, MODE_TX_ONLY, MODE_EM_R2, MODE_MOD_R2
    } port_mode_t;

endpackage

// ---- em_far_side.sv ----
// Far-side model: WAN link signaling and PCM plus the analog trunk leads.
module em_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tog,
    input wire logic e_lvl,
    input wire logic m_lvl,
    output logic [3:0] tx_abcd_in,
    output logic [3:0] rx_abcd_in,
    output logic e_lead_in,
    output logic m_lead_pin,
    output logic [7:0] pcm_from_net,
    output logic [7:0] pcm_from_user,
    output logic [7:0] tone_300,
    output logic [7:0] tone_1k,
    output logic [7:0] tone_3k,
    output logic [7:0] quiet_code
);
    timeunit 1ns;
    timeprecision 1ns;
    // Fixed tone codes; the values are arbitrary but all distinct.
    assign tone_300 = 8'h30;
    assign tone_1k = 8'h1a;
    assign tone_3k = 8'h3c;
    assign quiet_code = 8'hff;
    assign tx_abcd_in = 4'h6;
    // PCM changes every cycle so that a stale or wrong path shows.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pcm_from_net <= 8'h00;
            pcm_from_user <= 8'h00;
        end
        else
        begin
            pcm_from_net <= pcm_from_net + 8'h01;
            pcm_from_user <= pcm_from_user - 8'h01;
        end
    end
    // Bit A of receive signaling flips each cycle while tog is high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_abcd_in <= 4'h4;
        else
            rx_abcd_in <= {3'h2, rx_abcd_in[0] ^ tog};
    end
    // Trunk leads follow the levels the bench asks for.
    always_ff @(posedge pclk)
    begin
        e_lead_in <= e_lvl;
        m_lead_pin <= m_lvl;
    end
endmodule

// ---- tb.sv ----
// Self-checking bench driving the port test block over APB.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, port_active, wan_active;
    logic cross_connect, strap_trunk, tog, e_lvl, m_lvl;
    logic e_lead_in, m_lead_pin, e_lead_out, transition_alarm, irq;
    logic pready, pslverr;
    logic [7:0] paddr, pcm_from_net, pcm_from_user, tone_300, tone_1k;
    logic [7:0] tone_3k, quiet_code, pcm_user_side_tone_inject, pcm_to_net;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] base_status, tx_abcd_in, rx_abcd_in;
    logic [3:0] tx_abcd_out, rx_abcd_out;
    logic [1:0] port_mode, strap_type;
    int n_fail = 0;
    int samples_checked = 0;
    int k;
    // The clock toggles every 50 ns, half of a 100 ns period.
    always #50 pclk = ~pclk;
    em_port_test_sigmon #(.WINDOW_CYCLES(4000)) i_em_port_test_sigmon (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_active(port_active),
        .wan_active(wan_active), .cross_connect(cross_connect),
        .base_status(base_status), .port_mode(port_mode),
        .strap_type(strap_type), .strap_trunk(strap_trunk),
        .tx_abcd_in(tx_abcd_in), .rx_abcd_in(rx_abcd_in),
        .e_lead_in(e_lead_in), .m_lead_pin(m_lead_pin),
        .pcm_from_net(pcm_from_net), .pcm_from_user(pcm_from_user),
        .tone_300(tone_300), .tone_1k(tone_1k), .tone_3k(tone_3k),
        .quiet_code(quiet_code), .tx_abcd_out(tx_abcd_out),
        .rx_abcd_out(rx_abcd_out), .e_lead_out(e_lead_out),
        .pcm_user_side_tone_inject(pcm_user_side_tone_inject), .pcm_to_net(pcm_to_net),
        .transition_alarm(transition_alarm), .irq(irq));
    em_far_side i_em_far_side (
        .pclk(pclk), .presetn(presetn), .tog(tog), .e_lvl(e_lvl),
        .m_lvl(m_lvl), .tx_abcd_in(tx_abcd_in), .rx_abcd_in(rx_abcd_in),
        .e_lead_in(e_lead_in), .m_lead_pin(m_lead_pin),
        .pcm_from_net(pcm_from_net), .pcm_from_user(pcm_from_user),
        .tone_300(tone_300), .tone_1k(tone_1k), .tone_3k(tone_3k),
        .quiet_code(quiet_code));
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Let n edges pass, then step clear of the edge so outputs settle.
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    // Read a register and compare one field of it.
    task automatic rf(input logic [7:0] a, input int sh,
        input logic [31:0] m, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, (q >> sh) & m);
    endtask
    // Expected sample on a path for a given tone selection.
    function automatic logic [7:0] tone_exp(input int t,
        input logic [7:0] pass);
        case (t)
            1: return tone_300;
            2: return tone_1k;
            3: return tone_3k;
            4: return quiet_code;
            default: return pass;
        endcase
    endfunction
    task automatic end_of_test();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A hang is cut short well beyond the longest expected run.
    initial
    begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
    initial
    begin
        {psel, penable, pwrite, tog, e_lvl, m_lvl, strap_trunk} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        {port_active, wan_active, cross_connect} = 3'h7;
        base_status = 4'h8;
        port_mode = 2'h0;
        strap_type = 2'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rf(em_test_pkg::OFF_CTRL, 0, 32'hffffffff, 32'h0, "ctrl");
        rf(em_test_pkg::OFF_MONITOR, 0, 32'h1, 32'h0, "mon");
        rf(8'h40, 0, 32'hffffffff, 32'h0, "unmapped");
        // The slave never signals an error, so the flag must stay low.
        chk("slverr", 32'h0, pslverr);
        // Every status code passes through while no override is set.
        for (int i = 0; i < 12; i++)
        begin
            base_status <= i[3:0];
            rf(em_test_pkg::OFF_STATUS, 0, 32'h3f, i + 16, "st");
        end
        port_active <= 1'b0;
        rf(em_test_pkg::OFF_STATUS, 4, 32'h3, 32'h0, "test_na");
        port_active <= 1'b1;
        wan_active <= 1'b0;
        rf(em_test_pkg::OFF_STATUS, 4, 32'h3, 32'h0, "wan_na");
        wan_active <= 1'b1;
        apb(1'b1, em_test_pkg::OFF_CTRL, 32'ha1);
        cyc(3);
        chk("tx_out", 32'ha, tx_abcd_out);
        rf(em_test_pkg::OFF_READBACK, 0, 32'hf, 32'ha, "rb_tx");
        rf(em_test_pkg::OFF_STATUS, 0, 32'hf, 32'ha, "st_test");
        rf(em_test_pkg::OFF_STATUS, 4, 32'h3, 32'h2, "test_on");
        apb(1'b1, em_test_pkg::OFF_CTRL, 32'h502);
        cyc(3);
        chk("tx_mon", 32'h6, tx_abcd_out);
        chk("rx_out", 32'h5, rx_abcd_out);
        rf(em_test_pkg::OFF_READBACK, 4, 32'hf, 32'h5, "rb_rx");
        // Bus-connect drops the receive override and the tones.
        cross_connect <= 1'b0;
        cyc(3);
        chk("rx_bus", rx_abcd_in, rx_abcd_out);
        rf(em_test_pkg::OFF_STATUS, 8, 32'h7, 32'h7, "user_na");
        rf(em_test_pkg::OFF_STATUS, 12, 32'h7, 32'h7, "net_na");
        cross_connect <= 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            e_lvl <= ~v[0];
            apb(1'b1, em_test_pkg::OFF_CTRL, 4 | (v << 3));
            cyc(3);
            chk("e_out", v, e_lead_out);
            rf(em_test_pkg::OFF_READBACK, 8, 32'h1, v, "rb_e");
        end
        apb(1'b1, em_test_pkg::OFF_CTRL, 32'h0);
        m_lvl <= 1'b1;
        cyc(8);
        rf(em_test_pkg::OFF_READBACK, 9, 32'h1, 32'h1, "rb_m");
        for (int i = 0; i < 4; i++)
        begin
            port_mode <= i[1:0];
            strap_type <= i[1:0];
            strap_trunk <= i[0];
            rf(em_test_pkg::OFF_READBACK, 12, 32'h3, i, "mode");
            rf(em_test_pkg::OFF_READBACK, 16, 32'h3, i, "type");
            rf(em_test_pkg::OFF_READBACK, 18, 32'h1, i[0], "trk");
        end
        // Each tone selection in both directions, PCM first.
        for (int t = 0; t < 5; t++)
        begin
            apb(1'b1, em_test_pkg::OFF_TONE, t | (t << 4));
            cyc(3);
            chk("user_side_tone_inject", tone_exp(t, pcm_from_net - 8'h01),
                pcm_user_side_tone_inject);
            chk("to_net", tone_exp(t, pcm_from_user + 8'h01),
                pcm_to_net);
            rf(em_test_pkg::OFF_STATUS, 8, 32'h7, t, "st_user");
        end
        apb(1'b1, em_test_pkg::OFF_TONE, 32'h0);
        // A long burst alarms and raises the sticky event.
        apb(1'b1, em_test_pkg::OFF_MONITOR, 32'h1);
        rf(em_test_pkg::OFF_MONITOR, 0, 32'h1, 32'h1, "mon_on");
        tog <= 1'b1;
        cyc(600);
        tog <= 1'b0;
        cyc(3);
        chk("alarm", 32'h1, transition_alarm);
        rf(em_test_pkg::OFF_IRQ_STATUS, 0, 32'h1, 32'h1, "irq_st");
        chk("irq_masked", 32'h0, irq);
        apb(1'b1, em_test_pkg::OFF_IRQ_MASK, 32'h1);
        cyc(1);
        chk("irq_on", 32'h1, irq);
        // The alarm falling marks a window edge to count from.
        k = 0;
        while (transition_alarm === 1'b1 && k < 5000)
        begin
            cyc(1);
            k++;
        end
        chk("alarm_clr", 32'h0, transition_alarm);
        apb(1'b1, em_test_pkg::OFF_IRQ_STATUS, 32'h1);
        cyc(1);
        chk("irq_w1c", 32'h0, irq);
        tog <= 1'b1;
        cyc(255);
        tog <= 1'b0;
        cyc(4);
        chk("alarm_255", 32'h0, transition_alarm);
        tog <= 1'b1;
        cyc(1);
        tog <= 1'b0;
        cyc(3);
        chk("alarm_256", 32'h1, transition_alarm);
        apb(1'b1, em_test_pkg::OFF_MONITOR, 32'h1);
        tog <= 1'b1;
        cyc(300);
        tog <= 1'b0;
        cyc(3);
        chk("alarm_off", 32'h0, transition_alarm);
        end_of_test();
    end
endmodule
